/* shared/flash_cmd_consts.vh */
// Purpose: Offsets, field positions and reset values of the flash command status block
// Assumes: 32-bit AHB-Lite words, one register per word
// Notes: Offsets are word indices; the byte address is four times the index
`ifndef FLASH_CMD_CONSTS_VH
`define FLASH_CMD_CONSTS_VH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define IDX_CONFIG 6'h04
`define IDX_STATUS 6'h05
`define IDX_SECURITY 6'h01
`define IDX_PROTECT 6'h06
`define IDX_CONTROL 6'h07
`define IDX_CMD 6'h08
`define IDX_KEY 6'h09

// ****************************************
// Status field positions
// ****************************************
`define ST_CBE 7
`define ST_CPL 6
`define ST_PROT_ERR 5
`define ST_ACC_ERR 4
`define ST_BLANK 2
`define ST_FAIL 1
`define ST_DONE 0

// ****************************************
// Config and control fields
// ****************************************
`define CFG_EMPTY_IE 7
`define CFG_CPL_IE 6
`define CFG_KEY_ARM 5
`define CTL_WAIT 0
`define CTL_STOP 1
`define CTL_DEBUG 2
`define CTL_SPECIAL 3

// ****************************************
// Reset values, encodings, command code and timing
// ****************************************
`define STATUS_RESET 8'hc0
`define PROTECT_RESET 8'hff
`define SEC_UNSECURE 2'h2
`define GATE_OPEN 2'h2
`define CMD_MASS_ERASE 8'h41
`define EXEC_CYCLES 8'h10

`endif

/* rtl/cmd_engine.v */
// Purpose: Stand-in for the high-voltage engine: runs one command for a fixed count
// Assumes: Start pulses only when idle
// Notes: Abort ends the command at once, dropping high voltage
`timescale 1ns/1ns
`include "flash_cmd_consts.vh"
module cmd_engine (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // Control
   input wire start,
   input wire abort,
   // Status
   output reg busy_q,
   output reg done_q
);
   reg [7:0] cnt_q;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         cnt_q <= 8'h00;
      end else begin
         done_q <= 1'b0;
         if (abort) begin
            busy_q <= 1'b0;
         end else if (start) begin
            busy_q <= 1'b1;
            cnt_q <= `EXEC_CYCLES;
         end else if (busy_q) begin
            if (cnt_q == 8'h01) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end
endmodule // cmd_engine

/* rtl/flash_cmd_status_security.v */
// Purpose: Status, mode handling and security of the flash command controller
// Assumes: AHB-Lite single word transfers; stored security byte and key are inputs
// Notes: Command sequence: word write to IDX_CMD buffers data; clearing CBE launches
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ns
`include "flash_cmd_consts.vh"
module flash_cmd_status_security (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // Stored configuration from the array
   input wire [7:0] stored_security,
   input wire [63:0] stored_key,
   // Array result
   input wire blank_result,
   // Mode signals from the system
   input wire wait_mode,
   input wire stop_mode,
   input wire debug_mode,
   input wire special_mode,
   // Outputs
   output reg buffer_empty_irq,
   output reg complete_irq,
   output reg wake_req,
   output reg secure_q,
   output reg high_voltage_on
);
   // ****************************************
   // Mode input synchronisers
   // ****************************************
   reg [3:0] mode_m_q;
   reg [3:0] mode_s_q;
   wire wait_s = mode_s_q[`CTL_WAIT];
   wire stop_s = mode_s_q[`CTL_STOP];
   wire dbg_s = mode_s_q[`CTL_DEBUG];
   wire spec_s = mode_s_q[`CTL_SPECIAL];

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_m_q <= 4'h0;
         mode_s_q <= 4'h0;
      end else begin
         mode_m_q <= {special_mode, debug_mode, stop_mode, wait_mode};
         mode_s_q <= mode_m_q;
      end
   end

   // ****************************************
   // Bus address phase capture
   // ****************************************
   reg ph_wr_q;
   reg [5:0] ph_idx_q;
   // Whole-word transfers only; narrower ones are ignored
   wire take = hsel & hready & htrans[1] & (hsize == 3'h2);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_wr_q <= 1'b0;
         ph_idx_q <= 6'h00;
      end else begin
         ph_wr_q <= take & hwrite;
         ph_idx_q <= haddr[7:2];
      end
   end

   function wr_hit;
      input [5:0] idx;
      begin
         wr_hit = ph_wr_q & (ph_idx_q == idx);
      end
   endfunction

   // ****************************************
   // Registers
   // ****************************************
   reg cbe_q, cpl_q, prot_err_q, acc_err_q, fail_q, blank_q;
   reg empty_ie_q, cpl_ie_q, key_arm_q;
   reg [7:0] prot_q;
   reg seq_q;
   reg [7:0] cmd_buf_q;
   reg pend_q;
   reg [7:0] pend_cmd_q;
   reg stop_d1_q;
   reg sec_eval_q;
   reg [1:0] key_cnt_q;
   reg key_ok_q;
   wire eng_busy, eng_done;
   wire stop_entry = stop_s & ~stop_d1_q;
   wire stop_exit = ~stop_s & stop_d1_q;
   wire [7:0] wbyte = hwdata[7:0];
   wire st_wr = wr_hit(`IDX_STATUS);
   // Launch on CBE clear after a command write
   wire launch = st_wr & wbyte[`ST_CBE] & cbe_q & seq_q & ~stop_s;
   // Only mass erase while secured in special single chip
   wire cmd_ok = ~(secure_q & spec_s) | (cmd_buf_q == `CMD_MASS_ERASE);
   // Held off in the stop exit cycle too, so a buffered command is dropped
   wire start_now = pend_q & ~eng_busy & ~stop_s & ~stop_d1_q;
   wire eng_abort = stop_entry & eng_busy;

   cmd_engine u_engine (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(start_now),
      .abort(eng_abort),
      .busy_q(eng_busy),
      .done_q(eng_done)
   );

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cbe_q <= 1'b1;
         cpl_q <= 1'b1;
         prot_err_q <= 1'b0;
         acc_err_q <= 1'b0;
         fail_q <= 1'b0;
         blank_q <= 1'b0;
         empty_ie_q <= 1'b0;
         cpl_ie_q <= 1'b0;
         key_arm_q <= 1'b0;
         prot_q <= `PROTECT_RESET;
         seq_q <= 1'b0;
         cmd_buf_q <= 8'h00;
         pend_q <= 1'b0;
         pend_cmd_q <= 8'h00;
         stop_d1_q <= 1'b0;
      end else begin
         stop_d1_q <= stop_s;
         if (wr_hit(`IDX_CONFIG)) begin
            empty_ie_q <= wbyte[`CFG_EMPTY_IE];
            cpl_ie_q <= wbyte[`CFG_CPL_IE];
            key_arm_q <= wbyte[`CFG_KEY_ARM];
         end
         if (wr_hit(`IDX_PROTECT) & dbg_s) begin
            prot_q <= wbyte;
         end
         if (wr_hit(`IDX_CMD) & cbe_q & ~key_arm_q) begin
            seq_q <= 1'b1;
            cmd_buf_q <= wbyte;
         end
         if (st_wr) begin
            // Write-one-to-clear error flags
            if (wbyte[`ST_PROT_ERR]) prot_err_q <= 1'b0;
            if (wbyte[`ST_ACC_ERR]) acc_err_q <= 1'b0;
            if (spec_s) fail_q <= wbyte[`ST_FAIL];
            if (!wbyte[`ST_CBE] && seq_q) begin
               seq_q <= 1'b0;
               acc_err_q <= 1'b1;
            end
         end
         if (launch) begin
            seq_q <= 1'b0;
            if (cmd_ok) begin
               cbe_q <= 1'b0;
               pend_q <= 1'b1;
               pend_cmd_q <= cmd_buf_q;
            end else begin
               acc_err_q <= 1'b1;
            end
         end
         // Buffer frees when the engine fetches it; wait mode does not stall this
         if (start_now) begin
            pend_q <= 1'b0;
            cbe_q <= 1'b1;
            blank_q <= (pend_cmd_q == 8'h05) & blank_result;
         end
         // Complete only when nothing active or buffered
         // Stop keeps the abort result until the buffered command is dropped on exit
         if ((~cbe_q & ~stop_s) | (launch & cmd_ok)) begin
            cpl_q <= 1'b0;
         end else if (eng_done & ~pend_q) begin
            cpl_q <= 1'b1;
         end
         if (eng_abort) begin
            cpl_q <= 1'b1;
            acc_err_q <= 1'b1;
         end
         if (stop_exit) begin
            cbe_q <= 1'b1;
            pend_q <= 1'b0;
            seq_q <= 1'b0;
            if (~eng_busy) cpl_q <= 1'b1;
         end
      end
   end

   // ****************************************
   // Security evaluation and backdoor key
   // ****************************************
   wire [1:0] sec_bits = stored_security[1:0];
   wire [1:0] gate_field = stored_security[7:6];
   wire key_wr = wr_hit(`IDX_KEY) & key_arm_q & (gate_field == `GATE_OPEN);
   wire [15:0] key_word = stored_key[{key_cnt_q, 4'h0} +: 16];
   wire word_ok = (hwdata[15:0] == key_word) & (hwdata[17:16] == key_cnt_q);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         secure_q <= 1'b1;
         sec_eval_q <= 1'b0;
         key_cnt_q <= 2'h0;
         key_ok_q <= 1'b1;
      end else begin
         // Sampled once after release, since a strap cannot load under reset
         if (!sec_eval_q) begin
            sec_eval_q <= 1'b1;
            secure_q <= (sec_bits != `SEC_UNSECURE);
         end
         if (!key_arm_q) begin
            key_cnt_q <= 2'h0;
            key_ok_q <= 1'b1;
         end else if (key_wr) begin
            // Word index in hwdata[17:16] stands for the key location
            key_cnt_q <= key_cnt_q + 2'h1;
            if (key_cnt_q == 2'h3) begin
               if (key_ok_q & word_ok) secure_q <= 1'b0;
               key_ok_q <= 1'b1;
            end else begin
               key_ok_q <= key_ok_q & word_ok;
            end
         end
      end
   end

   // ****************************************
   // Read mux and outputs
   // ****************************************
   reg [7:0] status_v;
   reg [7:0] rd_v;
   always @* begin
      status_v = 8'h00;
      status_v[`ST_CBE] = cbe_q;
      status_v[`ST_CPL] = cpl_q;
      status_v[`ST_PROT_ERR] = prot_err_q;
      status_v[`ST_ACC_ERR] = acc_err_q;
      status_v[`ST_BLANK] = blank_q;
      status_v[`ST_FAIL] = fail_q & spec_s;
      status_v[`ST_DONE] = ~eng_busy & spec_s;
      // Decoded from the address phase so the data stands for the whole data phase
      case (haddr[7:2])
         `IDX_STATUS: rd_v = status_v;
         `IDX_CONFIG: rd_v = {empty_ie_q, cpl_ie_q, key_arm_q, 5'h00};
         `IDX_PROTECT: rd_v = prot_q;
         `IDX_SECURITY: rd_v = {stored_security[7:2], secure_q ? 2'h3 : `SEC_UNSECURE};
         `IDX_CMD: rd_v = cmd_buf_q;
         default: rd_v = 8'h00;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         buffer_empty_irq <= 1'b0;
         complete_irq <= 1'b0;
         wake_req <= 1'b0;
         high_voltage_on <= 1'b0;
      end else begin
         // Limitation: a pipelined write in the same cycle is not yet visible
         hrdata <= (take & ~hwrite) ? {24'h000000, rd_v} : 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         buffer_empty_irq <= cbe_q & empty_ie_q;
         complete_irq <= cpl_q & cpl_ie_q;
         wake_req <= wait_s & ((cbe_q & empty_ie_q) | (cpl_q & cpl_ie_q));
         high_voltage_on <= eng_busy & ~stop_s;
      end
   end
endmodule // flash_cmd_status_security

/* bench/cpu_master.sv */
// Purpose: CPU-side master issuing single-word AHB-Lite transfers
// Assumes: hreadyout of the one slave is the bus hready
// Notes: Waits as long as the slave stalls; the bench watchdog ends a hang
`timescale 1ns/1ns
module cpu_master (
   // Clock and answer
   input wire hclk,
   input wire hreadyout,
   input wire [31:0] hrdata,
   // Request
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // Caller keeps fail clear, clears errors and orders key words
   task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, idx, 2'b00};
      hwrite <= wr;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      rd = hrdata;
      // Released data lines must not look valid
      hwdata <= ~wd;
   endtask
endmodule // cpu_master

/* bench/flash_status_sva.sv */
// Purpose: Port-level assertions for the flash status block
// Assumes: Zero wait states, two-flop mode sync
// Notes: Helper counter stands in for reset age
`timescale 1ns/1ns
`include "flash_cmd_consts.vh"
module flash_status_sva (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // Bus
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hreadyout,
   // Side signals
   input wire [7:0] stored_security,
   input wire wait_mode,
   input wire stop_mode,
   input wire complete_irq,
   input wire wake_req,
   input wire secure_q,
   input wire high_voltage_on
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [2:0] age_q;
   logic key_q;
   logic key2_q;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         age_q <= 3'h0;
         key_q <= 1'b0;
         key2_q <= 1'b0;
      end else begin
         age_q <= age_q + {2'h0, age_q != 3'h7};
         key_q <= hsel && htrans[1] && hwrite && haddr[7:2] == `IDX_KEY;
         key2_q <= key_q;
      end
   end
   property p_ready; hreadyout; endproperty
   a_ready: assert property (p_ready)
      else $error("slave stalled");
   property p_stop_abort; $rose(stop_mode) && high_voltage_on |-> ##[1:5] !high_voltage_on; endproperty
   a_stop_abort: assert property (p_stop_abort)
      else $error("stop left engine on");
   property p_stop_hold; stop_mode && $past(stop_mode, 5) |-> !high_voltage_on; endproperty
   a_stop_hold: assert property (p_stop_hold)
      else $error("high voltage during stop");
   property p_wait_keep; $rose(wait_mode) && high_voltage_on && !stop_mode |-> high_voltage_on[*3]; endproperty
   a_wait_keep: assert property (p_wait_keep)
      else $error("wait aborted command");
   property p_busy; high_voltage_on && $past(high_voltage_on, 3) |-> !complete_irq; endproperty
   a_busy: assert property (p_busy)
      else $error("complete while busy");
   property p_wake; wait_mode && $past(wait_mode, 4) && complete_irq |-> ##[0:2] wake_req; endproperty
   a_wake: assert property (p_wake)
      else $error("no wake request");
   property p_sec; age_q == 3'h3 |-> secure_q == (stored_security[1:0] != `SEC_UNSECURE); endproperty
   a_sec: assert property (p_sec)
      else $error("security not evaluated");
   property p_key; $fell(secure_q) && age_q == 3'h7 |-> key_q || key2_q; endproperty
   a_key: assert property (p_key)
      else $error("unsecured without key");
endmodule // flash_status_sva
bind flash_cmd_status_security flash_status_sva chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hreadyout, .stored_security, .wait_mode, .stop_mode, .complete_irq, .wake_req, .secure_q, .high_voltage_on);

/* bench/flash_cmd_status_security_bench.sv */
// Purpose: Self-checking bench for the flash status block
// Assumes: Engine runs EXEC_CYCLES cycles
// Notes: Register rows first, then hand cases
`timescale 1ns/1ns
`include "flash_cmd_consts.vh"
module flash_cmd_status_security_bench;
   typedef struct packed {logic w; logic [5:0] a; logic [7:0] d;} row_t;
   localparam logic [7:0] err = `STATUS_RESET | (8'h01 << `ST_ACC_ERR);
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, blank_result;
   logic wait_mode, stop_mode, debug_mode, special_mode, buffer_empty_irq;
   logic complete_irq, wake_req, secure_q, high_voltage_on;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] stored_security;
   logic [63:0] stored_key;
   int fails, checked, n;
   // Reads expect d; zero and fail/done writes leave reset status
   row_t rows[9] = '{{1'b0, `IDX_STATUS, 8'hc0}, {1'b1, `IDX_STATUS, 8'h00}, {1'b0, `IDX_STATUS, 8'hc0},
      {1'b1, `IDX_STATUS, 8'h77}, {1'b0, `IDX_STATUS, 8'hc0}, {1'b0, `IDX_PROTECT, 8'hff},
      {1'b1, `IDX_PROTECT, 8'h00}, {1'b0, `IDX_PROTECT, 8'hff}, {1'b0, 6'h3f, 8'h00}};
   cpu_master m (.hclk, .hreadyout, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
   flash_cmd_status_security dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .stored_security, .stored_key, .blank_result,
      .wait_mode, .stop_mode, .debug_mode, .special_mode, .buffer_empty_irq, .complete_irq, .wake_req,
      .secure_q, .high_voltage_on);
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic tally_and_finish();
      if (fails == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      m.xfer(1'b1, a, {24'h0, d}, r);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] k);
      m.xfer(1'b0, a, 32'h0, r);
      chk({24'h0, r[7:0] & k}, {24'h0, e});
   endtask
   task automatic go(input logic [7:0] c);
      wr(`IDX_CMD, c);
      wr(`IDX_STATUS, 8'h80);
   endtask
   task automatic nc(input int k);
      repeat (k) @(negedge hclk);
   endtask
   task automatic idle();
      n = 0;
      while (high_voltage_on !== 1'b0 && n < 100) begin
         @(negedge hclk);
         n++;
      end
   endtask
   task automatic rst(input logic [7:0] s);
      @(posedge hclk);
      hresetn <= 1'b0;
      stored_security <= s;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      nc(3);
   endtask
   task automatic key(input logic [1:0] k);
      m.xfer(1'b1, `IDX_KEY, {14'h0, k, stored_key[16*k +: 16]}, r);
   endtask
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      fails++;
      tally_and_finish();
   end
   initial begin
      {hresetn, blank_result, wait_mode, stop_mode, debug_mode, special_mode} = 6'h0;
      stored_security = 8'h82;
      stored_key = 64'h1357_2468_9abc_def0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         else rd(rows[i].a, rows[i].d, 8'hff);
      end
      // ***
      // Interrupt levels, completion, abort
      // ***
      wr(`IDX_CONFIG, 8'hc0);
      nc(2);
      chk({30'h0, buffer_empty_irq, complete_irq}, 32'h3);
      wr(`IDX_CONFIG, 8'h00);
      nc(2);
      chk({30'h0, buffer_empty_irq, complete_irq}, 32'h0);
      go(8'h20);
      rd(`IDX_STATUS, 8'h00, 8'h40);
      idle();
      rd(`IDX_STATUS, 8'hc0, 8'hff);
      wr(`IDX_CMD, 8'h20);
      wr(`IDX_STATUS, 8'h00);
      rd(`IDX_STATUS, err, 8'hff);
      wr(`IDX_STATUS, 8'h10);
      rd(`IDX_STATUS, 8'hc0, 8'hff);
      // Buffered second command keeps complete low
      wr(`IDX_CONFIG, 8'h40);
      go(8'h20);
      go(8'h20);
      n = 0;
      while (complete_irq !== 1'b1 && n < 200) begin
         @(negedge hclk);
         n++;
      end
      chk({31'h0, n > `EXEC_CYCLES + 4}, 32'h1);
      // ***
      // Wait and stop
      // ***
      go(8'h20);
      // Enter wait only once high voltage is up, so the keep check has work
      repeat (3) @(posedge hclk);
      wait_mode <= 1'b1;
      idle();
      nc(4);
      chk({31'h0, wake_req}, 32'h1);
      @(posedge hclk);
      wait_mode <= 1'b0;
      go(8'h20);
      go(8'h20);
      @(posedge hclk);
      stop_mode <= 1'b1;
      nc(6);
      chk({31'h0, high_voltage_on}, 32'h0);
      rd(`IDX_STATUS, 8'h50, 8'h50);
      @(posedge hclk);
      stop_mode <= 1'b0;
      nc(20);
      chk({31'h0, high_voltage_on}, 32'h0);
      rd(`IDX_STATUS, err, 8'hd0);
      wr(`IDX_STATUS, 8'h10);
      // ***
      // Special, debug, security
      // ***
      @(posedge hclk);
      {special_mode, debug_mode} <= 2'h3;
      nc(3);
      wr(`IDX_STATUS, 8'h03);
      rd(`IDX_STATUS, 8'hc3, 8'hff);
      wr(`IDX_PROTECT, 8'h5a);
      rd(`IDX_PROTECT, 8'h5a, 8'hff);
      rst(8'h80);
      chk({31'h0, secure_q}, 32'h1);
      go(8'h20);
      rd(`IDX_STATUS, 8'h10, 8'h10);
      wr(`IDX_STATUS, 8'h10);
      go(`CMD_MASS_ERASE);
      nc(3);
      chk({31'h0, high_voltage_on}, 32'h1);
      idle();
      wr(`IDX_CONFIG, 8'h20);
      key(2'h1);
      key(2'h0);
      key(2'h2);
      key(2'h3);
      chk({31'h0, secure_q}, 32'h1);
      for (int k = 0; k < 4; k++) key(k[1:0]);
      nc(2);
      chk({31'h0, secure_q}, 32'h0);
      rst(8'h80);
      chk({31'h0, secure_q}, 32'h1);
      rst(8'h82);
      chk({31'h0, secure_q}, 32'h0);
      // Closed gate field: a correct key must not unsecure
      rst(8'h00);
      wr(`IDX_CONFIG, 8'h20);
      for (int k = 0; k < 4; k++) key(k[1:0]);
      nc(2);
      chk({31'h0, secure_q}, 32'h1);
      tally_and_finish();
   end
endmodule // flash_cmd_status_security_bench
